/* verilog/rus_defs.svh */
// Purpose: Offsets, reset values and timing figures for the boot sequencer
// Assumes: 125 MHz core clock
// Notes:   Included by the boot sequencer design file only
`ifndef RUS_DEFS_SVH
`define RUS_DEFS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define RUS_ADDR_W        4
`define RUS_OFF_DWELL     4'h0
`define RUS_OFF_STATUS    4'h4
`define RUS_OFF_START     4'h8
`define RUS_OFF_DUMMY     4'hC

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define RUS_ST_CODE_LSB   0
`define RUS_ST_HB_BIT     4
`define RUS_ST_APP_BIT    5
`define RUS_ST_ERR_BIT    6
`define RUS_ST_RCFG_BIT   7

// ----------------------------------------------------------------------
// Flash layout and reset values
// ----------------------------------------------------------------------
`define RUS_APP_ADDR      32'h0040_0000
`define RUS_FACTORY_ADDR  32'h0000_0000
`define RUS_DUMMY_CYCLES  4'h8
`define RUS_CODE_OFF      3'h0
`define RUS_CODE_ALL      3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RUS_CLK_MHZ       125
`define RUS_APP_BLINK_S   7
`define RUS_DWELL_MS      1000
`define RUS_HB_MS         100

`endif

/* verilog/rus_pkg.sv */
// Purpose: Types shared by the boot sequencer files
// Assumes: rus_defs.svh on the include path
// Notes:   State codes are the indicator codes, except hold, which shows indicators off
package rus_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RUS_S_RESET   = 3'b000,
        RUS_S_RELEASE = 3'b001,
        RUS_S_EMPTY   = 3'b010,
        RUS_S_APPSEL  = 3'b011,
        RUS_S_ADDR    = 3'b100,
        RUS_S_WDOG    = 3'b101,
        RUS_S_BOOT    = 3'b110,
        RUS_S_HOLD    = 3'b111
    } rus_state_t;

endpackage

/* verilog/rus_tick.sv */
// Purpose: Programmable period tick generator
// Assumes: Period of zero behaves as one
// Notes:   Clear restarts the period
`timescale 1ns/100ps
`default_nettype none

module rus_tick #(
    parameter int W = 32
) (
    input  wire logic         CORE_CLK_I,
    input  wire logic         RESETN_I,
    input  wire logic         clr_i,
    input  wire logic [W-1:0] period_i,
    output logic              tick_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         wrap;

    assign wrap  = (cnt_q + W'(1) >= period_i);
    // Restart at one: the cleared cycle already counts toward the period
    assign cnt_d = clr_i ? W'(1) : (wrap ? '0 : cnt_q + W'(1));

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_o <= wrap && !clr_i;
        end
    end

endmodule

`default_nettype wire

/* verilog/rus_boot_seq.sv */
// Purpose: Boot sequencer driving the on-chip remote update circuitry
// Assumes: One clock, synchronous active-low reset, Avalon-MM register slave
// Notes:   APP_MODE_I selects the application-image behaviour at reset
//
// Contract
// - Start in factory image, end handing to application
// - Low indicators show 3-bit state code
// - State 3'b100 loads application start address
// - Heartbeat toggles fast throughout factory image
// - Hold state: code outputs off, heartbeat continues
// - Application blinks codes 7 s, then reverts
// - Flash reads use 8 dummy clocks
// - Seven steps in fixed documented order
// - Entering boot raises reconfiguration trigger
// - Hold entered only on error, left by reset
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rus_defs.svh"

module rus_boot_seq #(
    parameter int unsigned DWELL_CYC = `RUS_DWELL_MS * `RUS_CLK_MHZ * 1000,
    parameter int unsigned HB_CYC    = `RUS_HB_MS * `RUS_CLK_MHZ * 1000,
    parameter int unsigned APP_CYC   = `RUS_APP_BLINK_S * `RUS_CLK_MHZ * 1000000
) (
    input  wire logic                   CORE_CLK_I,
    input  wire logic                   RESETN_I,
    input  wire logic                   APP_MODE_I,
    input  wire logic                   RU_ERROR_I,
    input  wire logic [`RUS_ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic                   AVS_READ_I,
    input  wire logic                   AVS_WRITE_I,
    input  wire logic [31:0]            AVS_WRITEDATA_I,
    output logic      [31:0]            AVS_READDATA_O,
    output logic                        AVS_WAITREQUEST_O,
    output logic      [2:0]             STATE_CODE_INDICATORS_O,
    output logic                        HEARTBEAT_INDICATOR_O,
    output logic                        RU_RESET_O,
    output logic                        RU_APPLICATION_NOT_FACTORY_SELECT_O,
    output logic      [31:0]            RU_START_ADDR_O,
    output logic                        RU_START_ADDR_WR_O,
    output logic                        RU_WATCHDOG_EN_O,
    output logic                        RU_RECONFIG_O,
    output logic      [3:0]             RU_DUMMY_CYCLES_O,
    output rus_pkg::rus_state_t         STATE_O
);
    import rus_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rus_state_t  st_q;
    rus_state_t  st_d;
    logic        strap_done_q;
    logic        app_q;
    logic        err_q;
    logic [31:0] dwell_q;
    logic [31:0] start_q;
    logic [31:0] app_cnt_q;
    logic        blink_q;
    logic        hb_q;
    logic        dwell_tick;
    logic        hb_tick;
    logic        st_change;
    logic        app_done;
    logic        run;
    logic        bus_req;
    logic        bus_acc;
    logic        wr_dwell;
    logic        wr_start;
    logic [31:0] rd_mux;
    logic [2:0]  code_d;

    // ------------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            strap_done_q <= 1'b0;
            app_q        <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            app_q        <= APP_MODE_I;
        end
    end

    assign run = strap_done_q && !app_q;

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    // programmable dwell
    rus_tick #(.W(32)) u_dwell (
        .CORE_CLK_I (CORE_CLK_I),
        .RESETN_I   (RESETN_I),
        .clr_i      (st_change),
        .period_i   (dwell_q),
        .tick_o     (dwell_tick)
    );

    rus_tick #(.W(32)) u_hb (
        .CORE_CLK_I (CORE_CLK_I),
        .RESETN_I   (RESETN_I),
        .clr_i      (1'b0),
        .period_i   (HB_CYC),
        .tick_o     (hb_tick)
    );

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // step order and hold
    always_comb begin
        st_d = st_q;
        if (run) begin
            if (RU_ERROR_I) begin
                st_d = RUS_S_HOLD;
            end else if (dwell_tick) begin
                case (st_q)
                    RUS_S_RESET:   st_d = RUS_S_RELEASE;
                    RUS_S_RELEASE: st_d = RUS_S_EMPTY;
                    RUS_S_EMPTY:   st_d = RUS_S_APPSEL;
                    RUS_S_APPSEL:  st_d = RUS_S_ADDR;
                    RUS_S_ADDR:    st_d = RUS_S_WDOG;
                    RUS_S_WDOG:    st_d = RUS_S_BOOT;
                    RUS_S_BOOT:    st_d = RUS_S_BOOT;
                    RUS_S_HOLD:    st_d = RUS_S_HOLD;
                    default:       st_d = RUS_S_HOLD;
                endcase
            end
        end
    end

    assign st_change = (st_d != st_q);
    assign app_done  = app_q && (app_cnt_q == APP_CYC - 1);

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            st_q <= RUS_S_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            app_cnt_q <= 32'h0000_0000;
            blink_q   <= 1'b0;
        end else if (app_q && !app_done) begin
            app_cnt_q <= app_cnt_q + 32'h0000_0001;
            blink_q   <= blink_q ^ dwell_tick;
        end
    end

    // Error flag stays until reset, matching the hold state
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            err_q <= 1'b0;
        end else if (run && RU_ERROR_I) begin
            err_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    // indicator code
    assign code_d = app_q               ? (blink_q ? `RUS_CODE_ALL : `RUS_CODE_OFF) :
                    (st_q == RUS_S_HOLD) ? `RUS_CODE_OFF : st_q;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            STATE_CODE_INDICATORS_O <= `RUS_CODE_OFF;
            hb_q                    <= 1'b0;
        end else begin
            STATE_CODE_INDICATORS_O <= code_d;
            hb_q                    <= app_q ? 1'b0 : hb_q ^ hb_tick;
        end
    end

    assign HEARTBEAT_INDICATOR_O = hb_q;

    // ------------------------------------------------------------------
    // Remote update controls
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            RU_RESET_O                          <= 1'b1;
            RU_APPLICATION_NOT_FACTORY_SELECT_O <= 1'b0;
            RU_START_ADDR_O                     <= `RUS_FACTORY_ADDR;
            RU_START_ADDR_WR_O                  <= 1'b0;
            RU_WATCHDOG_EN_O                    <= 1'b1;
            RU_RECONFIG_O                       <= 1'b0;
            RU_DUMMY_CYCLES_O                   <= `RUS_DUMMY_CYCLES;
            STATE_O                             <= RUS_S_RESET;
        end else begin
            STATE_O            <= st_q;
            RU_DUMMY_CYCLES_O  <= `RUS_DUMMY_CYCLES;
            // Keep the update circuitry in reset across the strap cycle
            RU_RESET_O         <= !strap_done_q || (run && (st_q == RUS_S_RESET));
            RU_START_ADDR_WR_O <= run && (st_q == RUS_S_ADDR) && (STATE_O != RUS_S_ADDR);
            if (run && st_q == RUS_S_ADDR) begin
                RU_START_ADDR_O <= start_q;
            end
            if (run && st_q == RUS_S_APPSEL) begin
                RU_APPLICATION_NOT_FACTORY_SELECT_O <= 1'b1;
            end
            if (run && st_q == RUS_S_WDOG) begin
                RU_WATCHDOG_EN_O <= 1'b0;
            end
            if (run && st_q == RUS_S_BOOT) begin
                RU_RECONFIG_O <= 1'b1;
            end
            if (app_done) begin
                RU_APPLICATION_NOT_FACTORY_SELECT_O <= 1'b0;
                RU_START_ADDR_O                     <= `RUS_FACTORY_ADDR;
                RU_RECONFIG_O                       <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then answer
    // ------------------------------------------------------------------
    assign bus_req  = AVS_READ_I || AVS_WRITE_I;
    assign bus_acc  = bus_req && !AVS_WAITREQUEST_O;
    assign wr_dwell = bus_acc && AVS_WRITE_I && (AVS_ADDRESS_I == `RUS_OFF_DWELL);
    assign wr_start = bus_acc && AVS_WRITE_I && (AVS_ADDRESS_I == `RUS_OFF_START);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (AVS_ADDRESS_I)
            `RUS_OFF_DWELL: rd_mux = dwell_q;
            `RUS_OFF_START: rd_mux = start_q;
            `RUS_OFF_DUMMY: rd_mux = {28'h000_0000, RU_DUMMY_CYCLES_O};
            `RUS_OFF_STATUS: begin
                rd_mux[`RUS_ST_CODE_LSB +: 3] = st_q;
                rd_mux[`RUS_ST_HB_BIT]        = hb_q;
                rd_mux[`RUS_ST_APP_BIT]       = app_q;
                rd_mux[`RUS_ST_ERR_BIT]       = err_q;
                rd_mux[`RUS_ST_RCFG_BIT]      = RU_RECONFIG_O;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= 32'h0000_0000;
        end else begin
            AVS_WAITREQUEST_O <= !(bus_req && AVS_WAITREQUEST_O);
            if (bus_req && AVS_WAITREQUEST_O) begin
                AVS_READDATA_O <= AVS_READ_I ? rd_mux : 32'h0000_0000;
            end
        end
    end

    // Dwell of zero would stall nothing but hide the codes
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            dwell_q <= DWELL_CYC;
            start_q <= `RUS_APP_ADDR;
        end else begin
            if (wr_dwell) begin
                dwell_q <= AVS_WRITEDATA_I;
            end
            if (wr_start) begin
                start_q <= AVS_WRITEDATA_I;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_enter_boot;
        run && st_q == RUS_S_BOOT && STATE_O != RUS_S_BOOT;
    endsequence

    sequence s_enter_addr;
        run && st_q == RUS_S_ADDR && STATE_O != RUS_S_ADDR;
    endsequence

    state_code_out_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        run && st_q != RUS_S_HOLD |=> STATE_CODE_INDICATORS_O == $past(st_q))
        else $error("state code indicators do not follow state");

    hold_leds_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        run && st_q == RUS_S_HOLD |=> STATE_CODE_INDICATORS_O == `RUS_CODE_OFF)
        else $error("indicators lit in hold state");

    hold_sticky_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        st_q == RUS_S_HOLD |=> st_q == RUS_S_HOLD [*3])
        else $error("hold state left without reset");

    addr_load_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        s_enter_addr |=> RU_START_ADDR_WR_O && RU_START_ADDR_O == start_q ##1 !RU_START_ADDR_WR_O)
        else $error("start address not loaded in address state");

    boot_trigger_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        s_enter_boot |=> RU_RECONFIG_O && RU_APPLICATION_NOT_FACTORY_SELECT_O && !RU_WATCHDOG_EN_O)
        else $error("reconfiguration not raised on boot entry");

    step_order_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        run && st_change && st_d != RUS_S_HOLD |-> st_d == st_q + 3'h1 && dwell_tick)
        else $error("sequencer skipped a step");

    heartbeat_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !app_q && hb_tick |=> HEARTBEAT_INDICATOR_O != $past(HEARTBEAT_INDICATOR_O))
        else $error("heartbeat did not toggle");

    app_revert_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        app_q && app_cnt_q == APP_CYC - 1 |=> RU_RECONFIG_O && !RU_APPLICATION_NOT_FACTORY_SELECT_O)
        else $error("application image did not revert to factory");

    error_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        run && RU_ERROR_I |=> st_q == RUS_S_HOLD ##1 STATE_CODE_INDICATORS_O == `RUS_CODE_OFF)
        else $error("error did not send sequencer to hold");

    dummy_cycles_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        strap_done_q |-> RU_DUMMY_CYCLES_O == `RUS_DUMMY_CYCLES)
        else $error("dummy clock count wrong");

    bus_answer_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wr_dwell |=> dwell_q == $past(AVS_WRITEDATA_I) && AVS_WAITREQUEST_O)
        else $error("dwell register write lost");

    ru_reset_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        !strap_done_q |=> RU_RESET_O)
        else $error("remote update reset dropped before sequencing");

endmodule

`default_nettype wire

/* bench/rus_ru_model.sv */
// Purpose: Model of the remote update circuitry and its two-image flash
// Assumes: Driven straight from the boot sequencer outputs
// Notes:   Error flag rises only when the bench commands it
`timescale 1ns/100ps
`default_nettype none

module rus_ru_model #(
    parameter logic [31:0] APP_BASE = 32'h0040_0000,
    parameter logic [31:0] FAC_BASE = 32'h0000_0000
) (
    input  wire logic        clk_i,
    input  wire logic        ru_reset_i,
    input  wire logic        app_sel_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        addr_wr_i,
    input  wire logic        reconfig_i,
    input  wire logic        err_cmd_i,
    output logic             error_o,
    output logic [31:0]      boot_addr_o,
    output logic             booted_o
);
    logic [31:0] addr_q   = 32'h0000_0000;
    logic        rcfg_q   = 1'b0;
    logic [31:0] boot_q   = 32'hFFFF_FFFF;
    logic        booted_q = 1'b0;

    assign error_o     = err_cmd_i;
    assign boot_addr_o = boot_q;
    assign booted_o    = booted_q;

    // ------------------------------------------------------------------
    // Image selection
    // ------------------------------------------------------------------
    // two halves, factory low
    always @(posedge clk_i) begin
        rcfg_q <= reconfig_i;
        if (ru_reset_i) begin
            addr_q   <= FAC_BASE;
            booted_q <= 1'b0;
        end else if (addr_wr_i) begin
            addr_q <= addr_i;
        end
        // Select low always means the factory half
        if (reconfig_i && !rcfg_q) begin
            boot_q   <= app_sel_i ? addr_q : FAC_BASE;
            booted_q <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* bench/test_rus_boot_seq.sv */
// Purpose: Self-checking bench for the boot sequencer
// Assumes: Short dwell, heartbeat and blink counts
// Notes:   Each scenario except t_regs starts from its own reset
`timescale 1ns/100ps
`default_nettype none

module test_rus_boot_seq;
    import rus_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        app_mode = 1'b0;
    logic        err_cmd = 1'b0;
    logic        ru_error;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wait_req;
    logic [2:0]  code;
    logic        hb;
    logic        ru_rst;
    logic        app_sel;
    logic [31:0] saddr;
    logic        saddr_wr;
    logic        wdog;
    logic        rcfg;
    logic [3:0]  dummy;
    rus_state_t  st;
    logic [31:0] boot_addr;
    logic        booted;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    rus_boot_seq #(.DWELL_CYC(20), .HB_CYC(4), .APP_CYC(200)) i_rus_boot_seq (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .APP_MODE_I(app_mode), .RU_ERROR_I(ru_error),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_req),
        .STATE_CODE_INDICATORS_O(code), .HEARTBEAT_INDICATOR_O(hb), .RU_RESET_O(ru_rst),
        .RU_APPLICATION_NOT_FACTORY_SELECT_O(app_sel), .RU_START_ADDR_O(saddr),
        .RU_START_ADDR_WR_O(saddr_wr), .RU_WATCHDOG_EN_O(wdog), .RU_RECONFIG_O(rcfg),
        .RU_DUMMY_CYCLES_O(dummy), .STATE_O(st));

    rus_ru_model i_rus_ru_model (
        .clk_i(clk), .ru_reset_i(ru_rst), .app_sel_i(app_sel), .addr_i(saddr),
        .addr_wr_i(saddr_wr), .reconfig_i(rcfg), .err_cmd_i(err_cmd),
        .error_o(ru_error), .boot_addr_o(boot_addr), .booted_o(booted));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr  <= a;
        wr   <= w;
        rd   <= !w;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        q  = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) chk("waitrequest", 32'h1, 32'h0);
    endtask

    task automatic do_reset(input logic app);
        @(posedge clk);
        rst_n    <= 1'b0;
        app_mode <= app;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic wait_chg(output int n);
        logic [2:0] c;
        c = code;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (code === c && n < 300);
    endtask

    task automatic hb_count(output int t);
        logic h;
        t = 0;
        repeat (40) begin
            h = hb;
            @(posedge clk);
            if (hb !== h) t++;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_factory;
        logic [31:0] q;
        int          n;
        int          t0;
        do_reset(1'b0);
        bus(1'b1, 4'h0, 32'd12, q);
        chk("first code", {29'h0, code}, 32'h0);
        chk("ru reset", {31'h0, ru_rst}, 32'h1);
        t0 = cyc;
        for (int s = 1; s <= 6; s++) begin
            wait_chg(n);
            chk("code", {29'h0, code}, s);
            if (s == 3) chk("dwell", cyc - t0, 32'd12);
            t0 = cyc;
            repeat (3) @(posedge clk);
            chk("ru reset low", {31'h0, ru_rst}, 32'h0);
            if (s == 4) chk("start addr", saddr, 32'h0040_0000);
            if (s >= 3) chk("select", {31'h0, app_sel}, 32'h1);
            chk("watchdog", {31'h0, wdog}, {31'h0, (s < 5)});
            chk("reconfig", {31'h0, rcfg}, {31'h0, (s == 6)});
        end
        chk("boot image", boot_addr, 32'h0040_0000);
        chk("booted", {31'h0, booted}, 32'h1);
        hb_count(n);
        chk("heartbeat", {31'h0, (n >= 8)}, 32'h1);
        chk("stay boot", {29'h0, code}, 32'h6);
        $display("test factory done");
    endtask

    task automatic t_regs;
        logic [31:0] q;
        bus(1'b0, 4'h0, 32'h0, q);
        chk("dwell reg", q, 32'd12);
        bus(1'b0, 4'h8, 32'h0, q);
        chk("start reg", q, 32'h0040_0000);
        bus(1'b1, 4'hC, 32'h5, q);
        bus(1'b0, 4'hC, 32'h0, q);
        chk("dummy reg", q, 32'h8);
        chk("dummy out", {28'h0, dummy}, 32'h8);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", q, 32'h0);
        bus(1'b0, 4'h4, 32'h0, q);
        // Heartbeat bit moves between capture and return; app test covers it
        chk("status", q & 32'hEF, 32'h86);
        $display("test regs done");
    endtask

    task automatic t_error;
        logic [31:0] q;
        int          n;
        do_reset(1'b0);
        wait_chg(n);
        wait_chg(n);
        err_cmd <= 1'b1;
        repeat (4) @(posedge clk);
        err_cmd <= 1'b0;
        chk("hold code", {29'h0, code}, 32'h0);
        chk("hold state", {29'h0, st}, {29'h0, RUS_S_HOLD});
        hb_count(n);
        chk("hold heartbeat", {31'h0, (n >= 8)}, 32'h1);
        repeat (100) @(posedge clk);
        chk("hold stays", {29'h0, st}, {29'h0, RUS_S_HOLD});
        chk("no reconfig", {31'h0, rcfg}, 32'h0);
        bus(1'b0, 4'h4, 32'h0, q);
        chk("sticky err", {31'h0, q[6]}, 32'h1);
        $display("test error done");
    endtask

    task automatic t_app;
        logic [31:0] q;
        int   n;
        logic seen_on;
        logic seen_off;
        logic other;
        do_reset(1'b1);
        err_cmd  <= 1'b1;
        seen_on  = 1'b0;
        seen_off = 1'b0;
        other    = 1'b0;
        n        = 0;
        while (rcfg !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
            if (n > 4 && code === 3'h7) seen_on = 1'b1;
            else if (n > 4 && code === 3'h0) seen_off = 1'b1;
            else if (n > 4) other = 1'b1;
        end
        err_cmd <= 1'b0;
        chk("blink", {29'h0, seen_on, seen_off, other}, 32'h6);
        chk("blink span", {31'h0, (n >= 195 && n <= 206)}, 32'h1);
        repeat (2) @(posedge clk);
        chk("revert select", {31'h0, app_sel}, 32'h0);
        chk("revert addr", saddr, 32'h0);
        chk("revert image", boot_addr, 32'h0);
        chk("app heartbeat", {31'h0, hb}, 32'h0);
        bus(1'b0, 4'h4, 32'h0, q);
        chk("app status", q & 32'hFF, 32'hA0);
        $display("test app done");
    endtask

    // ------------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        t_factory();
        t_regs();
        t_error();
        t_app();
        conclude();
    end

    // Whole run is near 600 cycles
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule

`default_nettype wire
